// file: rtl/rx_check_pkg.sv
package rx_check_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [3:0] IDX_EMD_SUPPRESS = 4'h5;
    localparam logic [3:0] IDX_SST_TIMER    = 4'h6;
    localparam logic [3:0] IDX_RX_AUX       = 4'ha;

    // receive_aux_config fields
    localparam int AUX_NO_CRC    = 7;
    localparam int AUX_IDENT_HI  = 5;
    localparam int AUX_IDENT_LO  = 4;
    localparam int AUX_PHASE_SEL = 3;
    localparam int AUX_DIS_CORR  = 2;
    localparam int AUX_COUNT_HI  = 1;
    localparam int AUX_COUNT_LO  = 0;

    // emd_suppress_config fields
    localparam int EMD_ENABLE    = 7;
    localparam int EMD_START_TOL = 6;
    localparam int EMD_THLD_HI   = 3;
    localparam int EMD_THLD_LO   = 0;

    // subcarrier_start_timer field
    localparam int SST_HI = 4;
    localparam int SST_LO = 0;

    // Writable bits of each register
    localparam logic [7:0] AUX_MASK = 8'hbf;
    localparam logic [7:0] EMD_MASK = 8'hcf;
    localparam logic [7:0] SST_MASK = 8'h1f;

    // Values after reset
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] EMD_RESET = 8'h00;
    localparam logic [7:0] SST_RESET = 8'h00;

    // Identifier size codes and lengths in bytes
    localparam logic [1:0] IDENT_CODE_4B = 2'b00;
    localparam logic [1:0] IDENT_CODE_7B = 2'b01;
    localparam logic [3:0] IDENT_LEN_4B  = 4'h4;
    localparam logic [3:0] IDENT_LEN_7B  = 4'h7;

    // Quarter etu at 106 kbit/s is 32 carrier periods
    localparam int CLK_KHZ  = 25000;
    localparam int QETU_NS  = 2360;
    localparam int QETU_CYC = (QETU_NS * CLK_KHZ) / 1000000;

    // Subcarrier detection latency in quarter etu, short and long correlator start
    localparam logic [5:0] SC_DET_SHORT_QETU = 6'h02;
    localparam logic [5:0] SC_DET_LONG_QETU  = 6'h04;

    typedef enum logic [1:0] {
        SST_IDLE    = 2'b01,
        SST_MEASURE = 2'b10
    } sst_state_t;

endpackage

// file: rtl/rx_frame_check.sv
// How it works
// - CRC bypass bit skips CRC check, all protocols
// - Auto CRC skip after request/wake-up, anticollision
// - Identifier code 00 four bytes, 01 seven
// - Bit 3 selects quadrature phase clock
// - Bit 2 zero means correlation reception
// - Two-bit n feeds field-on direct commands
// - Enable bit turns disturbance suppression on
// - Start tolerance governs type A start indication
// - Short erroneous frame counts as disturbance
// - Start time in quarter etu, type B
// - Early subcarrier raises soft error
// - Suppression on: discard, raise restart instead
`timescale 1ns/1ps
`default_nettype none

module rx_frame_check
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    // Avalon-MM register slave, word addressed
    input  wire logic [3:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    // Protocol and command context from the transceiver
    input  wire logic        proto_a106_i,
    input  wire logic        proto_b106_i,
    input  wire logic        tx_request_sent_i,
    input  wire logic        anticoll_active_i,
    input  wire logic        correlator_start_len_i,
    // Receive framer events
    input  wire logic        rx_frame_start_i,
    input  wire logic        first4_done_i,
    input  wire logic        first4_err_i,
    input  wire logic        rx_frame_end_i,
    input  wire logic        rx_frame_err_i,
    input  wire logic [7:0]  rx_byte_count_i,
    input  wire logic        mask_receive_timer_done_i,
    input  wire logic        subcarrier_det_i,
    // Configuration to the receiver and command engine
    output logic             crc_check_en_o,
    output logic [3:0]       ident_len_o,
    output logic             phase_clk_quadrature_sel_o,
    output logic             correlation_en_o,
    output logic [1:0]       field_on_count_o,
    // Frame outcome
    output logic             rx_started_o,
    output logic             frame_accept_o,
    output logic             emd_suppress_o,
    output logic             soft_err_irq_o,
    output logic             restart_irq_o
);
    import rx_check_pkg::*;

    // Registers
    logic [7:0] aux_q;
    logic [7:0] emd_q;
    logic [7:0] sst_q;

    // Bus slave state
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        bus_req;
    logic        wr_commit;
    logic [7:0]  rd_value;

    // Receive state
    logic       auto_no_crc_q;
    logic       emd_en;
    logic       start_tol;
    logic [3:0] emd_thld;
    logic [5:0] sst_limit;
    logic [5:0] det_len;
    logic       early_sc;
    logic       short_err_frame;
    logic       sst_start;
    logic       frame_discard;
    logic       emd_event;

    // Decoded fields of receive_aux_config
    logic       no_crc_bit;
    logic [1:0] ident_code;
    logic       phase_bit;
    logic       dis_corr_bit;
    logic [1:0] count_field;

    assign bus_req   = read_i || write_i;
    // A write lands on the edge where the master sees waitrequest low
    assign wr_commit = write_i && !wait_q && byteenable_i[0];

    assign emd_en    = emd_q[EMD_ENABLE];
    assign start_tol = emd_q[EMD_START_TOL];
    assign emd_thld  = emd_q[EMD_THLD_HI:EMD_THLD_LO];

    assign no_crc_bit   = aux_q[AUX_NO_CRC];
    assign ident_code   = aux_q[AUX_IDENT_HI:AUX_IDENT_LO];
    assign phase_bit    = aux_q[AUX_PHASE_SEL];
    assign dis_corr_bit = aux_q[AUX_DIS_CORR];
    assign count_field  = aux_q[AUX_COUNT_HI:AUX_COUNT_LO];

    // Bus slave: one wait cycle on every access
    // Fixed latency costs a cycle but keeps the handshake trivial
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wait_q <= 1'b1;
        else if (bus_req && wait_q)
            wait_q <= 1'b0;
        else
            wait_q <= 1'b1;
    end

    always_comb
    begin
        unique case (address_i)
            IDX_RX_AUX:       rd_value = aux_q & AUX_MASK;
            IDX_EMD_SUPPRESS: rd_value = emd_q & EMD_MASK;
            IDX_SST_TIMER:    rd_value = sst_q & SST_MASK;
            default:          rd_value = 8'h00;
        endcase
    end

    // Read data captured during the wait cycle of a read, held until the next read
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_q <= 32'h0000_0000;
        else if (read_i && wait_q)
            rdata_q <= {24'h00_0000, rd_value};
    end

    assign readdata_o    = rdata_q;
    assign waitrequest_o = wait_q;

    // Register writes; unmapped addresses are ignored
    // Reserved bits are masked on the way in, so they never read back set
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            aux_q <= AUX_RESET;
        else if (wr_commit && address_i == IDX_RX_AUX)
            aux_q <= writedata_i[7:0] & AUX_MASK;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            emd_q <= EMD_RESET;
        else if (wr_commit && address_i == IDX_EMD_SUPPRESS)
            emd_q <= writedata_i[7:0] & EMD_MASK;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sst_q <= SST_RESET;
        else if (wr_commit && address_i == IDX_SST_TIMER)
            sst_q <= writedata_i[7:0] & SST_MASK;
    end

    // Static configuration outputs
    // Registered so the receiver never sees a half-updated field
    // Reserved codes fall back to the four byte identifier
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ident_len_o <= IDENT_LEN_4B;
        else if (ident_code == IDENT_CODE_7B)
            ident_len_o <= IDENT_LEN_7B;
        else
            ident_len_o <= IDENT_LEN_4B;
    end

    // Software keeps this low while PM demodulation is in use
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            phase_clk_quadrature_sel_o <= 1'b0;
        else
            phase_clk_quadrature_sel_o <= phase_bit;
    end

    // The set value has no defined receiver; it only drops correlation
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            correlation_en_o <= 1'b1;
        else
            correlation_en_o <= !dis_corr_bit;
    end

    // Sampled by the command engine at the start of a field-on command
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            field_on_count_o <= 2'b00;
        else
            field_on_count_o <= count_field;
    end

    // CRC checking
    // Armed by a request/wake-up transmission, lasts for the answer frame
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            auto_no_crc_q <= 1'b0;
        else if (tx_request_sent_i)
            auto_no_crc_q <= 1'b1;
        else if (rx_frame_end_i)
            auto_no_crc_q <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            crc_check_en_o <= 1'b1;
        else
            crc_check_en_o <= !(no_crc_bit
                                || auto_no_crc_q
                                || anticoll_active_i);
    end

    // Reception start indication
    // Type A 106k waits for the first four bits; others start at once
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rx_started_o <= 1'b0;
        else if (proto_a106_i)
            rx_started_o <= first4_done_i && (start_tol || !first4_err_i);
        else
            rx_started_o <= rx_frame_start_i;
    end

    // Subcarrier start timing, type B 106k only
    // Detection latency is added so the limit matches the true start
    assign det_len   = correlator_start_len_i ? SC_DET_LONG_QETU : SC_DET_SHORT_QETU;
    assign sst_limit = {1'b0, sst_q[SST_HI:SST_LO]} + det_len;
    // Other protocols never arm the timer, so they cannot raise a soft error
    assign sst_start = mask_receive_timer_done_i && proto_b106_i;

    sst_timer u_sst_timer
    (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .start_i      (sst_start),
        .abort_i      (rx_frame_end_i),
        .subcarrier_i (subcarrier_det_i),
        .limit_i      (sst_limit),
        .early_o      (early_sc)
    );

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            soft_err_irq_o <= 1'b0;
        else
            soft_err_irq_o <= early_sc && !emd_en;
    end

    // Disturbance suppression
    // Parity and CRC must stay enabled by the host for this to be meaningful
    assign short_err_frame = rx_frame_err_i && ({4'h0, emd_thld} > rx_byte_count_i);
    assign frame_discard   = emd_en && rx_frame_end_i && short_err_frame;
    // One event feeds both strobes so they can never disagree
    assign emd_event       = (emd_en && early_sc) || frame_discard;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            restart_irq_o <= 1'b0;
        else
            restart_irq_o <= emd_event;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            emd_suppress_o <= 1'b0;
        else
            emd_suppress_o <= emd_event;
    end

    // A frame is passed on unless suppression discards it
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            frame_accept_o <= 1'b0;
        else
            frame_accept_o <= rx_frame_end_i && !frame_discard;
    end

endmodule

`default_nettype wire

// file: rtl/sst_timer.sv
`timescale 1ns/1ps
`default_nettype none

module sst_timer
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    // Measurement control
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic       subcarrier_i,
    input  wire logic [5:0] limit_i,
    // Result
    output logic            early_o
);
    import rx_check_pkg::*;

    localparam logic [6:0] QETU_LAST = 7'(QETU_CYC - 1);

    sst_state_t state_q;
    logic [6:0] div_q;
    logic [5:0] qcnt_q;
    logic       qtick;

    assign qtick = (div_q == QETU_LAST);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_q <= SST_IDLE;
        else
        begin
            unique case (state_q)
                SST_IDLE:
                    if (start_i)
                        state_q <= SST_MEASURE;
                SST_MEASURE:
                    if (subcarrier_i || abort_i)
                        state_q <= SST_IDLE;
            endcase
        end
    end

    // Quarter etu divider restarts with each measurement
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            div_q  <= 7'h00;
            qcnt_q <= 6'h00;
        end
        else if (state_q == SST_IDLE)
        begin
            div_q  <= 7'h00;
            qcnt_q <= 6'h00;
        end
        else
        begin
            div_q <= qtick ? 7'h00 : div_q + 7'h01;
            // Saturates so a late subcarrier never wraps to look early
            if (qtick && qcnt_q != 6'h3f)
                qcnt_q <= qcnt_q + 6'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            early_o <= 1'b0;
        else
            early_o <= (state_q == SST_MEASURE) && subcarrier_i && (qcnt_q < limit_i);
    end

endmodule

`default_nettype wire

// file: tb/card_model.sv
`timescale 1ns/1ps
`default_nettype none

module card_model
(
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    // Reply order: kind 0 frame, 1 subcarrier, 2 first bits
    input  wire logic        go_i,
    input  wire logic [1:0]  kind_i,
    input  wire logic [15:0] delay_i,
    input  wire logic        err_i,
    input  wire logic [7:0]  bytes_i,
    // Events towards the framer
    output logic             mrt_done_o,
    output logic             sc_det_o,
    output logic             start_o,
    output logic             end_o,
    output logic             end_err_o,
    output logic [7:0]       count_o,
    output logic             f4_done_o,
    output logic             f4_err_o
);
    logic [15:0] cnt_q;
    logic        fire;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_q <= 16'h0;
        else if (go_i)
            cnt_q <= delay_i;
        else if (cnt_q != 16'h0)
            cnt_q <= cnt_q - 16'h1;
    end

    assign fire       = cnt_q == 16'h1;
    assign mrt_done_o = go_i && kind_i == 2'h1;
    assign sc_det_o   = fire && kind_i == 2'h1;
    assign start_o    = go_i && kind_i == 2'h0;
    assign end_o      = fire && kind_i == 2'h0;
    assign f4_done_o  = go_i && kind_i == 2'h2;
    // Qualifiers invert outside their strobe, so a stale value is never mistaken for valid
    assign end_err_o  = end_o ? err_i : !err_i;
    assign count_o    = end_o ? bytes_i : ~bytes_i;
    assign f4_err_o   = f4_done_o ? err_i : !err_i;
endmodule

`default_nettype wire

// file: tb/rx_frame_check_props.sv
`timescale 1ns/1ps
`default_nettype none

module rx_frame_check_props
(
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       rstn_i,
    // Register bus
    input wire logic       read_i,
    input wire logic       write_i,
    input wire logic       waitrequest_o,
    // Receive context and events
    input wire logic       tx_request_sent_i,
    input wire logic       proto_a106_i,
    input wire logic       first4_done_i,
    input wire logic       first4_err_i,
    input wire logic       rx_frame_end_i,
    input wire logic       rx_frame_err_i,
    input wire logic [7:0] rx_byte_count_i,
    input wire logic       subcarrier_det_i,
    // Outcome
    input wire logic       crc_check_en_o,
    input wire logic       rx_started_o,
    input wire logic       frame_accept_o,
    input wire logic       emd_suppress_o,
    input wire logic       soft_err_irq_o,
    input wire logic       restart_irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("wait not dropped");
    a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("wait low too long");
    a_auto_crc_skip: assert property (tx_request_sent_i && !rx_frame_end_i |-> ##2 !crc_check_en_o)
        else $error("crc still checked");
    a_frame_outcome: assert property (rx_frame_end_i |=> frame_accept_o != restart_irq_o)
        else $error("frame outcome");
    a_clean_accept: assert property (rx_frame_end_i && (!rx_frame_err_i || rx_byte_count_i > 8'h0e)
        |=> frame_accept_o)
        else $error("clean frame dropped");
    a_restart_pair: assert property (restart_irq_o |-> emd_suppress_o && !soft_err_irq_o)
        else $error("restart unpaired");
    a_start_clean: assert property (proto_a106_i && first4_done_i && !first4_err_i |=> rx_started_o)
        else $error("no start");
    a_soft_cause: assert property (soft_err_irq_o |-> $past(subcarrier_det_i, 2))
        else $error("soft error uncaused");
endmodule

bind rx_frame_check rx_frame_check_props i_props (
    .clock_i, .rstn_i, .read_i, .write_i, .waitrequest_o, .tx_request_sent_i, .proto_a106_i,
    .first4_done_i, .first4_err_i, .rx_frame_end_i, .rx_frame_err_i, .rx_byte_count_i,
    .subcarrier_det_i, .crc_check_en_o, .rx_started_o, .frame_accept_o, .emd_suppress_o,
    .soft_err_irq_o, .restart_irq_o
);

`default_nettype wire

// file: tb/tb_rx_frame_check.sv
`timescale 1ns/1ps
`default_nettype none

module tb_rx_frame_check;
    import rx_check_pkg::*;
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [3:0]  address_i = 4'h0;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic        proto_a106_i = 1'b0;
    logic        proto_b106_i = 1'b0;
    logic        tx_request_sent_i = 1'b0;
    logic        anticoll_active_i = 1'b0;
    logic        correlator_start_len_i = 1'b0;
    logic        go = 1'b0;
    logic        clr = 1'b0;
    logic [1:0]  kind = 2'h0;
    logic [15:0] dly = 16'h1;
    logic        ferr = 1'b0;
    logic [7:0]  nbytes = 8'h0;
    logic [4:0]  seen = 5'h0;
    logic        rx_frame_start_i, first4_done_i, first4_err_i, rx_frame_end_i, rx_frame_err_i;
    logic        mask_receive_timer_done_i, subcarrier_det_i, waitrequest_o, crc_check_en_o;
    logic        phase_clk_quadrature_sel_o, correlation_en_o, rx_started_o, frame_accept_o;
    logic        emd_suppress_o, soft_err_irq_o, restart_irq_o;
    logic [7:0]  rx_byte_count_i;
    logic [31:0] readdata_o;
    logic [31:0] rdata;
    logic [3:0]  ident_len_o;
    logic [1:0]  field_on_count_o;
    logic [3:0]  regs [3] = '{IDX_EMD_SUPPRESS, IDX_SST_TIMER, IDX_RX_AUX};
    logic [7:0]  masks [3] = '{EMD_MASK, SST_MASK, AUX_MASK};
    logic [7:0]  aux_v [8] = '{8'h80, 8'h10, 8'h30, 8'h08, 8'h04, 8'h03, 8'h02, 8'h00};
    int          n_errors = 0;
    int          n_tests = 0;

    rx_frame_check i_dut (
        .clock_i, .rstn_i, .address_i, .read_i, .write_i, .byteenable_i(4'hf), .writedata_i,
        .readdata_o, .waitrequest_o, .proto_a106_i, .proto_b106_i, .tx_request_sent_i,
        .anticoll_active_i, .correlator_start_len_i, .rx_frame_start_i, .first4_done_i,
        .first4_err_i, .rx_frame_end_i, .rx_frame_err_i, .rx_byte_count_i,
        .mask_receive_timer_done_i, .subcarrier_det_i, .crc_check_en_o, .ident_len_o,
        .phase_clk_quadrature_sel_o, .correlation_en_o, .field_on_count_o, .rx_started_o,
        .frame_accept_o, .emd_suppress_o, .soft_err_irq_o, .restart_irq_o
    );

    card_model i_card (
        .clock_i, .rstn_i, .go_i(go), .kind_i(kind), .delay_i(dly), .err_i(ferr), .bytes_i(nbytes),
        .mrt_done_o(mask_receive_timer_done_i), .sc_det_o(subcarrier_det_i),
        .start_o(rx_frame_start_i), .end_o(rx_frame_end_i), .end_err_o(rx_frame_err_i),
        .count_o(rx_byte_count_i), .f4_done_o(first4_done_i), .f4_err_o(first4_err_i)
    );

    always #20 clock_i = ~clock_i;

    // Pulses seen since the last reply order, X sticks so it cannot pass
    always @(posedge clock_i)
        seen <= clr ? 5'h0 : seen | {rx_started_o, emd_suppress_o, frame_accept_o, restart_irq_o, soft_err_irq_o};

    task automatic finish_test();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        address_i <= a;
        writedata_i <= {24'h0, d};
        write_i <= w;
        read_i <= !w;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 20);
        rdata = readdata_o;
        if (n >= 20)
            n_errors++;
        write_i <= 1'b0;
        read_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h0);
        chk("readdata", {24'h0, e}, rdata);
    endtask

    task automatic run(input logic [1:0] k, input logic [15:0] d, input logic e, input logic [7:0] b,
                       input logic [4:0] x);
        kind <= k;
        dly <= d;
        ferr <= e;
        nbytes <= b;
        go <= 1'b1;
        clr <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        clr <= 1'b0;
        repeat (d + 16'h4) @(posedge clock_i);
        chk("pulses", 32'(x), 32'(seen));
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        finish_test();
    end

    initial
    begin
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        @(posedge clock_i);
        chk("crc_en", 32'h1, 32'(crc_check_en_o));
        foreach (regs[i])
        begin
            rdc(regs[i], 8'h00);
            bus(1'b1, regs[i], 8'hff);
            rdc(regs[i], masks[i]);
        end
        bus(1'b1, 4'h0, 8'hff);
        rdc(4'h0, 8'h00);
        bus(1'b1, IDX_EMD_SUPPRESS, 8'h00);
        foreach (aux_v[i])
        begin
            bus(1'b1, IDX_RX_AUX, aux_v[i]);
            repeat (2) @(posedge clock_i);
            chk("aux", 32'({!aux_v[i][7],
                aux_v[i][5:4] == IDENT_CODE_7B ? IDENT_LEN_7B : IDENT_LEN_4B,
                aux_v[i][3], !aux_v[i][2], aux_v[i][1:0]}), 32'({crc_check_en_o, ident_len_o,
                phase_clk_quadrature_sel_o, correlation_en_o, field_on_count_o}));
        end
        tx_request_sent_i <= 1'b1;
        @(posedge clock_i);
        tx_request_sent_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk("crc_en", 32'h0, 32'(crc_check_en_o));
        run(2'h0, 16'h4, 1'b1, 8'h2, 5'b10100);
        chk("crc_en", 32'h1, 32'(crc_check_en_o));
        anticoll_active_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk("crc_en", 32'h0, 32'(crc_check_en_o));
        anticoll_active_i <= 1'b0;
        bus(1'b1, IDX_EMD_SUPPRESS, 8'hc4);
        run(2'h0, 16'h4, 1'b1, 8'h3, 5'b11010);
        run(2'h0, 16'h4, 1'b1, 8'h4, 5'b10100);
        run(2'h0, 16'h4, 1'b0, 8'h1, 5'b10100);
        proto_a106_i <= 1'b1;
        run(2'h2, 16'h1, 1'b1, 8'h0, 5'b10000);
        bus(1'b1, IDX_EMD_SUPPRESS, 8'h84);
        run(2'h2, 16'h1, 1'b1, 8'h0, 5'b00000);
        run(2'h2, 16'h1, 1'b0, 8'h0, 5'b10000);
        run(2'h0, 16'h4, 1'b0, 8'h1, 5'b00100);
        proto_a106_i <= 1'b0;
        proto_b106_i <= 1'b1;
        bus(1'b1, IDX_EMD_SUPPRESS, 8'h04);
        bus(1'b1, IDX_SST_TIMER, 8'h08);
        run(2'h1, 16'd207, 1'b0, 8'h0, 5'b00001);
        run(2'h1, 16'd738, 1'b0, 8'h0, 5'b00000);
        run(2'h1, 16'd679, 1'b0, 8'h0, 5'b00000);
        correlator_start_len_i <= 1'b1;
        run(2'h1, 16'd679, 1'b0, 8'h0, 5'b00001);
        bus(1'b1, IDX_EMD_SUPPRESS, 8'hc4);
        run(2'h1, 16'd207, 1'b0, 8'h0, 5'b01010);
        proto_b106_i <= 1'b0;
        run(2'h1, 16'd207, 1'b0, 8'h0, 5'b00000);
        finish_test();
    end
endmodule

`default_nettype wire
